/* File: design/vsq_crt_file.v */
// crt controller indexed storage with registered read data
`timescale 1ns/10ps
module vsq_crt_file
(
    core_clk,
    wr_en,
    wr_addr,
    wr_data,
    rd_addr,
    rd_data
);
    input  wire       core_clk;  // host io clock
    input  wire       wr_en;     // write strobe
    input  wire [7:0] wr_addr;   // write index
    input  wire [7:0] wr_data;   // write byte
    input  wire [7:0] rd_addr;   // read index
    output reg  [7:0] rd_data;   // registered read byte

    reg [7:0] mem [0:255];       // crt controller and extension registers

    // ==========================================================
    // storage, contents undefined after power-on
    always @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* File: design/vsq_defines.vh */
// constants for the sequencer and crt controller register port
`ifndef VSQ_DEFINES_VH
`define VSQ_DEFINES_VH
// ==========================================================
// io port addresses
`define VSQ_SEQ_INDEX_PORT   16'h03c4
`define VSQ_SEQUENCER_DATA_PORT_PORT    16'h03c5
`define VSQ_MISC_WRITE_PORT  16'h03c2
`define VSQ_MISC_READ_PORT   16'h03cc
`define VSQ_CRT_MONO_BASE    16'h03b0
`define VSQ_CRT_COLOR_BASE   16'h03d0
`define VSQ_CRT_INDEX_OFS    16'h0004
`define VSQ_CRT_DATA_OFS     16'h0005
// ==========================================================
// sequencer indices
`define VSQ_IDX_RESET        5'h00
`define VSQ_IDX_CLOCKING     5'h01
`define VSQ_IDX_PLANE_WE     5'h02
`define VSQ_IDX_FONT         5'h03
`define VSQ_IDX_MEMMODE      5'h04
// ==========================================================
// writable bit masks
`define VSQ_MASK_RESET       8'h03
`define VSQ_MASK_CLOCKING    8'h3d
`define VSQ_MASK_PLANE_WE    8'h0f
`define VSQ_MASK_FONT        8'h3f
`define VSQ_MASK_MEMMODE     8'h0e
`define VSQ_MASK_SEQ_INDEX   8'h1f
// ==========================================================
// field positions
`define VSQ_CLK_EIGHT_DOT    0
`define VSQ_CLK_LOAD_SECOND  2
`define VSQ_CLK_HALF_DOT     3
`define VSQ_CLK_LOAD_FOURTH  4
`define VSQ_CLK_SCREEN_OFF   5
`define VSQ_MEM_EXTENDED     1
`define VSQ_MEM_SEQUENTIAL   2
`define VSQ_MEM_CHAIN_FOUR   3
`define VSQ_MISC_IO_SELECT   0
// ==========================================================
// reset values
`define VSQ_RESET_VALUE      8'h00
`endif

/* File: design/vsq_register_port.v */
// sequencer register bank with crt controller index and data ports
`timescale 1ns/10ps
`include "vsq_defines.vh"
module vsq_register_port
(
    core_clk,
    arst_n,
    io_addr,
    io_wr,
    io_rd,
    io_wdata,
    io_rdata,
    io_rvalid,
    attr_bit3,
    cpu_addr_low,
    eight_dot_char_select,
    serializer_load_every_second,
    half_dot_clock,
    serializer_load_every_fourth,
    screen_disable,
    plane_write_enable,
    extended_memory_access,
    sequential_addressing,
    chain_four_mode,
    io_base_select,
    font_region,
    font_switch_active,
    cpu_write_planes,
    cpu_read_plane
);
    // ==========================================================
    // host io bus
    input  wire        core_clk;                      // host io clock
    input  wire        arst_n;                        // asynchronous reset, low active
    input  wire [15:0] io_addr;                       // io port address
    input  wire        io_wr;                         // one-cycle write strobe
    input  wire        io_rd;                         // one-cycle read strobe
    input  wire [7:0]  io_wdata;                      // write byte
    output reg  [7:0]  io_rdata;                      // read byte
    output reg         io_rvalid;                     // read data valid pulse
    // ==========================================================
    // same-clock inputs from the display and memory paths
    input  wire        attr_bit3;                     // text attribute bit 3 (same clock)
    input  wire [1:0]  cpu_addr_low;                  // cpu address a1:a0 (same clock)
    // ==========================================================
    // registered controls toward the display and memory paths
    output reg         eight_dot_char_select;         // 1 = eight dot characters
    output reg         serializer_load_every_second;  // load every second char clock
    output reg         half_dot_clock;                // internal dot clock halved
    output reg         serializer_load_every_fourth;  // load every fourth char clock
    output reg         screen_disable;                // screen off
    output reg  [3:0]  plane_write_enable;            // plane write gates
    output reg         extended_memory_access;        // full 256k reach
    output reg         sequential_addressing;         // sequential cpu writes
    output reg         chain_four_mode;               // modulo four planes
    output reg         io_base_select;                // 0 mono, 1 color base
    output reg  [2:0]  font_region;                   // selected 8k region of plane 2
    output reg         font_switch_active;            // attribute bit 3 swaps fonts
    output reg  [3:0]  cpu_write_planes;              // planes a cpu write may touch
    output reg  [1:0]  cpu_read_plane;                // plane for chain four access

    // ==========================================================
    // register storage
    // reserved bits are left out or masked at write, so they read zero
    reg [4:0] sequencer_index;         // sequencer index value
    reg [1:0] sequencer_reset_compat;  // legacy reset bits
    reg [7:0] clocking_mode;           // clocking mode
    reg [3:0] plane_we_reg;            // plane write enable
    reg [5:0] font_bank_select;        // font select
    reg [7:0] memory_addressing_mode;  // memory mode
    reg [7:0] crt_controller_index;    // crt index
    reg       misc_io_select;          // io base select bit

    // ==========================================================
    // decode and read path nets
    wire [15:0] crt_base;              // current crt port base
    wire        hit_seq_idx;           // sequencer index port hit
    wire        hit_seq_dat;           // sequencer data port hit
    wire        hit_crt_idx;           // crt index port hit
    wire        hit_crt_dat;           // crt data port hit
    wire        hit_misc_w;            // misc output write hit
    wire        hit_misc_r;            // misc output read hit
    wire [7:0]  crt_rd;                // crt file read data
    reg         crt_rd_pend;           // crt read in flight
    reg  [7:0]  next_seq_rdata;        // sequencer read mux
    wire [2:0]  font_a_bank;           // font a region
    wire [2:0]  font_b_bank;           // font b region
    wire [15:0] crt_index_port;        // crt index port at current base
    wire [15:0] crt_data_port;         // crt data port at current base

    // ==========================================================
    // address decode
    assign crt_base    = misc_io_select ? `VSQ_CRT_COLOR_BASE : `VSQ_CRT_MONO_BASE;
    assign hit_seq_idx = (io_addr == `VSQ_SEQ_INDEX_PORT);
    assign hit_seq_dat = (io_addr == `VSQ_SEQUENCER_DATA_PORT_PORT);
    // mono and color groups share offsets; only the active base answers
    assign crt_index_port = crt_base + `VSQ_CRT_INDEX_OFS;
    assign crt_data_port  = crt_base + `VSQ_CRT_DATA_OFS;
    assign hit_crt_idx = (io_addr == crt_index_port);
    assign hit_crt_dat = (io_addr == crt_data_port);
    assign hit_misc_w  = (io_addr == `VSQ_MISC_WRITE_PORT);
    assign hit_misc_r  = (io_addr == `VSQ_MISC_READ_PORT);

    // font region decode: stored bit order {hi,lo1,lo0} maps hi to region lsb
    function [2:0] vsq_font_region;
        input [2:0] sel;  // {bit4or5, bit1or3, bit0or2}
        begin
            vsq_font_region = {sel[1], sel[0], sel[2]};
        end
    endfunction

    // without extended memory only regions 0 and 4 exist: keep the msb
    function [2:0] vsq_font_limit;
        input [2:0] region;  // decoded region
        input       ext;     // extended memory bit
        begin
            vsq_font_limit = ext ? region : {region[2], 2'b00};
        end
    endfunction

    assign font_b_bank = vsq_font_region({font_bank_select[4], font_bank_select[1:0]});
    assign font_a_bank = vsq_font_region({font_bank_select[5], font_bank_select[3:2]});

    // ==========================================================
    // crt controller storage, addressed by the held index
    // write and read share the index, so data accesses never move it
    vsq_crt_file u_crt_file
    (
        .core_clk (core_clk),
        .wr_en    (io_wr & hit_crt_dat),
        .wr_addr  (crt_controller_index),
        .wr_data  (io_wdata),
        .rd_addr  (crt_controller_index),
        .rd_data  (crt_rd)
    );

    // ==========================================================
    // host writes to index and sequencer registers
    // index, misc base bit and sequencer data share one process
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // every register starts from its power-on default
            sequencer_index        <= 5'h00;
            sequencer_reset_compat <= 2'b00;
            clocking_mode          <= `VSQ_RESET_VALUE;
            plane_we_reg           <= 4'h0;
            font_bank_select       <= 6'h00;
            memory_addressing_mode <= `VSQ_RESET_VALUE;
            crt_controller_index   <= `VSQ_RESET_VALUE;
            misc_io_select         <= 1'b0;
        end
        else if (io_wr)
        begin
            // index registers change only by direct write, never auto increment
            if (hit_seq_idx)
            begin
                sequencer_index <= io_wdata[4:0];
            end
            if (hit_crt_idx)
            begin
                crt_controller_index <= io_wdata;
            end
            if (hit_misc_w)
            begin
                // only the base select bit is kept here
                misc_io_select <= io_wdata[`VSQ_MISC_IO_SELECT];
            end
            if (hit_seq_dat)
            begin
                // masked storage keeps reserved bits at zero
                case (sequencer_index)
                    `VSQ_IDX_RESET:    sequencer_reset_compat <= io_wdata[1:0];
                    `VSQ_IDX_CLOCKING: clocking_mode <= io_wdata & `VSQ_MASK_CLOCKING;
                    `VSQ_IDX_PLANE_WE: plane_we_reg <= io_wdata[3:0];
                    `VSQ_IDX_FONT:     font_bank_select <= io_wdata[5:0];
                    `VSQ_IDX_MEMMODE:  memory_addressing_mode <= io_wdata & `VSQ_MASK_MEMMODE;
                    // indices 5..31 have no storage, writes vanish
                    default:           sequencer_index <= sequencer_index;
                endcase
            end
        end
    end

    // ==========================================================
    // sequencer read mux
    // narrow storage pads reserved bits with zeros
    always @*
    begin
        case (sequencer_index)
            `VSQ_IDX_RESET:    next_seq_rdata = {6'h00, sequencer_reset_compat};
            `VSQ_IDX_CLOCKING: next_seq_rdata = clocking_mode;
            `VSQ_IDX_PLANE_WE: next_seq_rdata = {4'h0, plane_we_reg};
            `VSQ_IDX_FONT:     next_seq_rdata = {2'b00, font_bank_select};
            `VSQ_IDX_MEMMODE:  next_seq_rdata = memory_addressing_mode;
            // indices without storage
            default:           next_seq_rdata = 8'h00;  // unmapped index reads zero
        endcase
    end

    // ==========================================================
    // read answer: one cycle for local registers, two for crt data
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            io_rdata    <= 8'h00;
            io_rvalid   <= 1'b0;
            crt_rd_pend <= 1'b0;
        end
        else
        begin
            io_rvalid   <= 1'b0;
            // crt data needs an extra cycle: the file registers its read
            crt_rd_pend <= io_rd & hit_crt_dat;
            // a pending crt answer wins; the host must not overlap it
            if (crt_rd_pend)
            begin
                io_rdata  <= crt_rd;
                io_rvalid <= 1'b1;
            end
            // local answers come straight from the registers
            else if (io_rd & ~hit_crt_dat)
            begin
                io_rvalid <= 1'b1;
                if (hit_seq_idx)
                    io_rdata <= {3'b000, sequencer_index};
                else if (hit_seq_dat)
                    io_rdata <= next_seq_rdata;
                else if (hit_crt_idx)
                    io_rdata <= crt_controller_index;
                else if (hit_misc_r)
                    io_rdata <= {7'h00, misc_io_select};
                // unmapped ports answer zero
                else
                    io_rdata <= 8'h00;
            end
        end
    end

    // ==========================================================
    // decoded controls registered toward the display and memory paths
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // controls idle while the registers are clear
            eight_dot_char_select        <= 1'b0;
            serializer_load_every_second <= 1'b0;
            half_dot_clock               <= 1'b0;
            serializer_load_every_fourth <= 1'b0;
            screen_disable               <= 1'b0;
            plane_write_enable           <= 4'h0;
            extended_memory_access       <= 1'b0;
            sequential_addressing        <= 1'b0;
            chain_four_mode              <= 1'b0;
            io_base_select               <= 1'b0;
            font_region                  <= 3'b000;
            font_switch_active           <= 1'b0;
            cpu_write_planes             <= 4'h0;
            cpu_read_plane               <= 2'b00;
        end
        else
        begin
            // clocking fields, one cycle behind the register
            eight_dot_char_select        <= clocking_mode[`VSQ_CLK_EIGHT_DOT];
            serializer_load_every_second <= clocking_mode[`VSQ_CLK_LOAD_SECOND];
            half_dot_clock               <= clocking_mode[`VSQ_CLK_HALF_DOT];
            serializer_load_every_fourth <= clocking_mode[`VSQ_CLK_LOAD_FOURTH];
            screen_disable               <= clocking_mode[`VSQ_CLK_SCREEN_OFF];
            // plane gating and memory mode fields
            plane_write_enable           <= plane_we_reg;
            extended_memory_access       <= memory_addressing_mode[`VSQ_MEM_EXTENDED];
            sequential_addressing        <= memory_addressing_mode[`VSQ_MEM_SEQUENTIAL];
            chain_four_mode              <= memory_addressing_mode[`VSQ_MEM_CHAIN_FOUR];
            // base select mirrored for the rest of the chip
            io_base_select               <= misc_io_select;
            // the switch is live only when the two selections differ
            font_switch_active           <= (font_a_bank != font_b_bank);
            // attribute bit 3 picks b or a only while the selections differ
            if ((font_a_bank != font_b_bank) && attr_bit3)
                font_region <= vsq_font_limit(font_b_bank, memory_addressing_mode[`VSQ_MEM_EXTENDED]);
            else
                font_region <= vsq_font_limit(font_a_bank, memory_addressing_mode[`VSQ_MEM_EXTENDED]);
            // plane routing for cpu access
            cpu_read_plane <= cpu_addr_low;
            // chain four: one plane picked by a1:a0
            if (memory_addressing_mode[`VSQ_MEM_CHAIN_FOUR])
                cpu_write_planes <= plane_we_reg & (4'h1 << cpu_addr_low);
            // sequential: every enabled plane
            else if (memory_addressing_mode[`VSQ_MEM_SEQUENTIAL])
                cpu_write_planes <= plane_we_reg;
            // odd/even: odd addresses reach planes 1 and 3
            else if (cpu_addr_low[0])
                cpu_write_planes <= plane_we_reg & 4'ha;
            // even addresses reach planes 0 and 2
            else
                cpu_write_planes <= plane_we_reg & 4'h5;
        end
    end
endmodule

/* File: verif/vsq_host_model.sv */
// host model issuing io port writes and reads
`timescale 1ns/10ps
module vsq_host_model
(
    input  wire        core_clk,
    input  wire [7:0]  io_rdata,
    input  wire        io_rvalid,
    output reg  [15:0] io_addr,
    output reg         io_wr,
    output reg         io_rd,
    output reg  [7:0]  io_wdata
);
    // idle bus from time zero
    initial
    begin
        io_addr  = 16'h0000;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end
    // strobe held over the taking edge; released lines show the inverse
    task io_write(input [15:0] a, input [7:0] d);
    begin
        @(negedge core_clk);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge core_clk);
        io_wr    = 1'b0;
        io_addr  = ~a;
        io_wdata = ~d;
    end
    endtask
    // read strobe, then no new request until the answer or three cycles
    task io_read(input [15:0] a, output [7:0] d, output ok);
        integer n;
    begin
        d  = 8'h00;
        ok = 1'b0;
        @(negedge core_clk);
        io_addr = a;
        io_rd   = 1'b1;
        @(negedge core_clk);
        io_rd   = 1'b0;
        io_addr = ~a;
        for (n = 0; n < 3 && !ok; n = n + 1)
        begin
            if (io_rvalid === 1'b1)
            begin
                ok = 1'b1;
                d  = io_rdata;
            end
            else
                @(negedge core_clk);
        end
    end
    endtask
endmodule

/* File: verif/vsq_register_port_assertions.sv */
// concurrent checks on the sequencer register port
`timescale 1ns/10ps
module vsq_register_port_assertions
(
    input wire        core_clk,
    input wire        arst_n,
    input wire [15:0] io_addr,
    input wire        io_wr,
    input wire        io_rd,
    input wire        io_rvalid,
    input wire [1:0]  cpu_addr_low,
    input wire        screen_disable,
    input wire        half_dot_clock,
    input wire [3:0]  plane_write_enable,
    input wire        extended_memory_access,
    input wire        sequential_addressing,
    input wire        chain_four_mode,
    input wire        io_base_select,
    input wire [2:0]  font_region,
    input wire [3:0]  cpu_write_planes
);
    // ==========================================
    // helpers
    wire all_planes = (plane_write_enable == 4'hf);  // plane gating cannot hide the mode
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    // ==========================================
    // checks
    chk_seq_read_answer: assert property (io_rd && io_addr == 16'h03c5 |=> io_rvalid)
        else $error("sequencer read not answered");
    chk_crt_read_late: assert property (
        io_rd && !io_base_select && io_addr == 16'h03b5 |=> !io_rvalid ##1 io_rvalid)
        else $error("crt read answer timing wrong");
    chk_answer_cause: assert property (io_rvalid |-> $past(io_rd) || $past(io_rd, 2))
        else $error("answer without a read");
    chk_write_silent: assert property (io_wr && !io_rd && !$past(io_rd) |=> !io_rvalid)
        else $error("write produced an answer");
    chk_controls_hold: assert property (!$past(io_wr, 2) |-> $stable({screen_disable,
        half_dot_clock, plane_write_enable, extended_memory_access, chain_four_mode,
        sequential_addressing, io_base_select}))
        else $error("control changed without a write");
    chk_chain_planes: assert property (
        chain_four_mode && $past(chain_four_mode) && all_planes && $past(all_planes)
        |-> cpu_write_planes == (4'h1 << $past(cpu_addr_low)))
        else $error("chain four plane wrong");
    chk_odd_even_planes: assert property (
        !chain_four_mode && !$past(chain_four_mode) && !sequential_addressing
        && !$past(sequential_addressing) && all_planes && $past(all_planes)
        |-> cpu_write_planes == ($past(cpu_addr_low[0]) ? 4'ha : 4'h5))
        else $error("odd even planes wrong");
    chk_font_bank_limit: assert property (
        !extended_memory_access && !$past(extended_memory_access) |-> font_region[1:0] == 2'h0)
        else $error("font bank outside 0 and 4");
    chk_reset_zero: assert property ($rose(arst_n) |-> font_region == 3'h0 && !screen_disable)
        else $error("outputs not clear after reset");
endmodule
bind vsq_register_port vsq_register_port_assertions u_checks (.*);

/* File: verif/vsq_register_port_bench.sv */
// self-checking bench for the sequencer register port
`timescale 1ns/10ps
module vsq_register_port_bench;
    localparam [39:0] MASKS = 40'h0e_3f0f_3d03;  // writable bits of indices 4..0
    reg         core_clk;                        // host io clock
    reg         arst_n;                          // asynchronous reset, low active
    reg         attr_bit3;                       // text attribute bit 3
    reg  [1:0]  cpu_addr_low;                    // cpu address a1:a0
    wire [15:0] io_addr;
    wire        io_wr, io_rd, io_rvalid, font_switch_active;
    wire [7:0]  io_wdata, io_rdata;
    wire        eight_dot_char_select, serializer_load_every_second, half_dot_clock;
    wire        serializer_load_every_fourth, screen_disable, io_base_select;
    wire        extended_memory_access, sequential_addressing, chain_four_mode;
    wire [3:0]  plane_write_enable, cpu_write_planes;
    wire [2:0]  font_region;
    wire [1:0]  cpu_read_plane;
    wire [7:0]  clk_bits = {3'h0, screen_disable, serializer_load_every_fourth, half_dot_clock,
                            serializer_load_every_second, eight_dot_char_select};
    wire [7:0]  mem_bits = {plane_write_enable, 1'b0, chain_four_mode, sequential_addressing,
                            extended_memory_access};
    integer     failures, samples_checked, i, k;
    reg  [7:0]  rd_val, fv;                      // read byte, font value
    reg         rd_ok;                           // read answered
    reg  [2:0]  exp_reg;                         // expected font region
    vsq_register_port u_dut (.*);
    vsq_host_model u_host (.*);
    // free running clock
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // region of the b and a selections, bit 4 or 5 as region lsb
    function [2:0] fb(input [7:0] v); fb = {v[1], v[0], v[4]}; endfunction
    function [2:0] fa(input [7:0] v); fa = {v[3], v[2], v[5]}; endfunction
    task check(input string what, input [7:0] seen, input [7:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task wr(input [15:0] a, input [7:0] d); u_host.io_write(a, d); endtask
    task sr(input [7:0] x, input [7:0] d); begin wr(16'h03c4, x); wr(16'h03c5, d); end endtask
    // a missing answer counts as a mismatch
    task rd(input string what, input [15:0] a, input [7:0] exp);
    begin
        u_host.io_read(a, rd_val, rd_ok);
        check({what, " answer"}, {7'h00, rd_ok}, 8'h01);
        check(what, rd_val, exp);
    end
    endtask
    // ==========================================
    // scenarios
    task t_reset_values;
    begin
        for (i = 0; i < 5; i = i + 1)
        begin
            wr(16'h03c4, i[7:0]);
            rd("seq reg at reset", 16'h03c5, 8'h00);
        end
        rd("misc at reset", 16'h03cc, 8'h00);
        rd("crt index at reset", 16'h03b4, 8'h00);
        $display("test reset_values done");
    end
    endtask
    // reset register written last must not clear the others
    task t_seq_masks;
    begin
        for (i = 4; i >= 0; i = i - 1)
        begin
            sr(i[7:0], 8'hff);
            rd("seq reg mask", 16'h03c5, MASKS[8*i +: 8]);
        end
        check("clock bits set", clk_bits, 8'h1f);
        check("mem bits set", mem_bits, 8'hf7);
        wr(16'h03c4, 8'hff);
        rd("seq index", 16'h03c4, 8'h1f);
        sr(8'h05, 8'hff);
        rd("unused index", 16'h03c5, 8'h00);
        for (i = 0; i < 5; i = i + 1)
            sr(i[7:0], 8'h00);
        repeat (2) @(negedge core_clk);
        check("clock bits clear", clk_bits, 8'h00);
        sr(8'h02, 8'h09);
        rd("plane enable", 16'h03c5, 8'h09);
        rd("plane enable again", 16'h03c5, 8'h09);
        check("plane enable out", mem_bits, 8'h90);
        $display("test seq_masks done");
    end
    endtask
    task t_planes;
    begin
        sr(8'h02, 8'h0f);
        for (k = 0; k < 8; k = k + 1)
        begin
            if (k == 0 || k == 4)
                sr(8'h04, (k == 0) ? 8'h00 : 8'h08);
            @(negedge core_clk);
            cpu_addr_low = k[1:0];
            repeat (2) @(negedge core_clk);
            check("read plane", {6'h00, cpu_read_plane}, {6'h00, k[1:0]});
            check("write planes", {4'h0, cpu_write_planes},
                  (k < 4) ? (k[0] ? 8'h0a : 8'h05) : (8'h01 << k[1:0]));
        end
        $display("test planes done");
    end
    endtask
    task t_font;
    begin
        for (k = 0; k < 12; k = k + 1)
        begin
            fv = (k < 4) ? 8'h2b : ((k < 8) ? 8'h12 : 8'h00);
            sr(8'h04, {6'h00, k[1], 1'b0});
            sr(8'h03, fv);
            @(negedge core_clk);
            attr_bit3 = k[0];
            repeat (2) @(negedge core_clk);
            exp_reg = k[0] ? fb(fv) : fa(fv);
            if (!k[1])
                exp_reg[1:0] = 2'h0;
            check("font region", {5'h00, font_region}, {5'h00, exp_reg});
            check("extended_memory_access", {7'h00, extended_memory_access}, {7'h00, k[1]});
            if (k[1])
                check("font switch", {7'h00, font_switch_active}, {7'h00, fa(fv) != fb(fv)});
        end
        $display("test font done");
    end
    endtask
    task t_crt;
    begin
        wr(16'h03b4, 8'h11);
        rd("crt index mono", 16'h03b4, 8'h11);
        wr(16'h03b5, 8'ha5);
        rd("crt data mono", 16'h03b5, 8'ha5);
        wr(16'h03d4, 8'h22);
        rd("crt index kept", 16'h03b4, 8'h11);
        rd("crt other base", 16'h03d5, 8'h00);
        wr(16'h03c2, 8'hff);
        rd("misc select", 16'h03cc, 8'h01);
        check("io base", {7'h00, io_base_select}, 8'h01);
        rd("crt data color", 16'h03d5, 8'ha5);
        wr(16'h03d4, 8'hfe);
        wr(16'h03d5, 8'h3c);
        rd("crt index full", 16'h03d4, 8'hfe);
        rd("crt data new", 16'h03d5, 8'h3c);
        wr(16'h03c2, 8'h00);
        $display("test crt done");
    end
    endtask
    // reset dropped between edges must clear at once
    task t_async_reset;
    begin
        sr(8'h01, 8'h20);
        sr(8'h03, 8'h3f);
        repeat (2) @(negedge core_clk);
        check("screen off", clk_bits, 8'h10);
        #20 arst_n = 1'b0;
        #10 check("clock after reset", clk_bits, 8'h00);
        check("font after reset", {5'h00, font_region}, 8'h00);
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        wr(16'h03c4, 8'h03);
        rd("font reg after reset", 16'h03c5, 8'h00);
        $display("test async_reset done");
    end
    endtask
    task stop_test;
    begin
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    // main sequence
    initial
    begin
        failures = 0;
        samples_checked = 0;
        arst_n = 1'b0;
        attr_bit3 = 1'b0;
        cpu_addr_low = 2'h0;
        repeat (20) @(negedge core_clk);
        arst_n = 1'b1;
        t_reset_values;
        t_seq_masks;
        t_planes;
        t_font;
        t_crt;
        t_async_reset;
        stop_test;
    end
    // watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures = failures + 1;
        stop_test;
    end
endmodule
